//--- inc/cxp_map.svh
// constants of the configuration extension port
`ifndef CXP_MAP_SVH
`define CXP_MAP_SVH
`define CXP_LEG_LO 10'h010
`define CXP_LEG_HI 10'h01f
`define CXP_EXT_LO 10'h100
`define CXP_EXT_HI 10'h3ff
`endif

//--- inc/cxp_pkg.sv
// types of the configuration extension port
package cxp_pkg;
	typedef struct packed {
		logic [9:0] reg_num;
		logic [7:0] func_num;
	} cxp_addr_t;
	typedef struct packed {
		logic [31:0] data;
		logic [3:0] be;
	} cxp_wr_t;
	typedef enum logic [1:0] {CXP_IDLE, CXP_PULSE, CXP_HOLD} cxp_state_t;
endpackage : cxp_pkg

//--- src/cxp_top.sv
// configuration extension port toward user register logic
`include "cxp_map.svh"
module cxp_top
	import cxp_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic LEG_EN,
	input wire logic EXT_EN,
	input wire logic LINK_RD,
	input wire logic LINK_WR,
	input wire cxp_addr_t LINK_ADDR,
	input wire cxp_wr_t LINK_WDATA,
	output logic LINK_BUSY,
	output logic LINK_RDONE,
	output logic [31:0] LINK_RDATA,
	output logic READ_RECEIVED,
	output logic WRITE_RECEIVED,
	output cxp_addr_t REQ_ADDR,
	output cxp_wr_t REQ_WDATA,
	input wire logic [31:0] READ_DATA,
	input wire logic READ_DATA_VALID
);
	////////////////////////////////////////////////////////////////
	cxp_state_t st_reg, st_next;
	logic rd_reg, rd_next, wr_reg, wr_next, done_reg, done_next;
	logic busy_reg, busy_next;
	cxp_addr_t addr_reg, addr_next;
	cxp_wr_t wd_reg, wd_next;
	logic [31:0] rdat_reg, rdat_next;
	logic in_user;
	logic cap;

	assign in_user = (LEG_EN && LINK_ADDR.reg_num >= `CXP_LEG_LO
		&& LINK_ADDR.reg_num <= `CXP_LEG_HI)
		|| (EXT_EN && LINK_ADDR.reg_num >= `CXP_EXT_LO
		&& LINK_ADDR.reg_num <= `CXP_EXT_HI);
	// only a held read accepts data; stray valids are dropped
	assign cap = (st_reg == CXP_HOLD) && READ_DATA_VALID;

	////////////////////////////////////////////////////////////////
	always_comb begin
		st_next = st_reg;
		rd_next = 1'b0;
		wr_next = 1'b0;
		done_next = 1'b0;
		addr_next = addr_reg;
		wd_next = wd_reg;
		rdat_next = rdat_reg;
		case (st_reg)
			CXP_IDLE: begin
				if (LINK_RD) begin
					rd_next = 1'b1;
					addr_next = LINK_ADDR;
					st_next = in_user ? CXP_HOLD : CXP_PULSE;
				end else if (LINK_WR) begin
					wr_next = 1'b1;
					addr_next = LINK_ADDR;
					wd_next = LINK_WDATA;
					st_next = CXP_PULSE;
				end
			end
			CXP_PULSE: begin
				// single-cycle strobe completes, no user data wanted
				done_next = ~wr_reg;
				rdat_next = '0;
				st_next = CXP_IDLE;
			end
			CXP_HOLD: begin
				if (cap) begin
					rdat_next = READ_DATA;
					done_next = 1'b1;
					st_next = CXP_IDLE;
				end else begin
					rd_next = 1'b1;
				end
			end
			default: st_next = CXP_IDLE;
		endcase
		busy_next = (st_next != CXP_IDLE);
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			st_reg <= CXP_IDLE;
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			done_reg <= 1'b0;
			addr_reg <= '0;
			wd_reg <= '0;
			rdat_reg <= '0;
			busy_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			rd_reg <= rd_next;
			wr_reg <= wr_next;
			done_reg <= done_next;
			addr_reg <= addr_next;
			wd_reg <= wd_next;
			rdat_reg <= rdat_next;
			busy_reg <= busy_next;
		end
	end

	////////////////////////////////////////////////////////////////
	assign READ_RECEIVED = rd_reg;
	assign WRITE_RECEIVED = wr_reg;
	assign REQ_ADDR = addr_reg;
	assign REQ_WDATA = wd_reg;
	assign LINK_RDONE = done_reg;
	assign LINK_RDATA = rdat_reg;
	assign LINK_BUSY = busy_reg;

	////////////////////////////////////////////////////////////////
	property p_rd_start;
		@(posedge SYS_CLK) disable iff (RST)
		(st_reg == CXP_IDLE && LINK_RD) |=> READ_RECEIVED;
	endproperty
	a_rd_start: assert property (p_rd_start) else $error("no read strobe");

	property p_pulse_nouser;
		@(posedge SYS_CLK) disable iff (RST)
		(st_reg == CXP_IDLE && LINK_RD && !LEG_EN && !EXT_EN)
		|=> READ_RECEIVED ##1 !READ_RECEIVED;
	endproperty
	a_pulse_nouser: assert property (p_pulse_nouser)
		else $error("read not one cycle");

	property p_hold;
		@(posedge SYS_CLK) disable iff (RST)
		(st_reg == CXP_HOLD && !READ_DATA_VALID) |=> READ_RECEIVED;
	endproperty
	a_hold: assert property (p_hold) else $error("held strobe dropped");

	property p_outside;
		@(posedge SYS_CLK) disable iff (RST)
		(st_reg == CXP_IDLE && LINK_RD && !in_user) |=> ##1 !READ_RECEIVED;
	endproperty
	a_outside: assert property (p_outside) else $error("outside held");

	property p_wr_pulse;
		@(posedge SYS_CLK) disable iff (RST)
		WRITE_RECEIVED |=> !WRITE_RECEIVED;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("write not pulse");

	property p_addr;
		@(posedge SYS_CLK) disable iff (RST)
		(st_reg == CXP_IDLE && (LINK_RD || LINK_WR))
		|=> REQ_ADDR == $past(LINK_ADDR);
	endproperty
	a_addr: assert property (p_addr) else $error("address wrong");

	property p_func_stable;
		@(posedge SYS_CLK) disable iff (RST)
		(READ_RECEIVED && $past(READ_RECEIVED))
		|-> REQ_ADDR.func_num == $past(REQ_ADDR.func_num);
	endproperty
	a_func_stable: assert property (p_func_stable)
		else $error("function moved");

	property p_wdata;
		@(posedge SYS_CLK) disable iff (RST)
		(st_reg == CXP_IDLE && !LINK_RD && LINK_WR)
		|=> WRITE_RECEIVED && REQ_WDATA == $past(LINK_WDATA);
	endproperty
	a_wdata: assert property (p_wdata) else $error("write data wrong");

	property p_capture;
		@(posedge SYS_CLK) disable iff (RST)
		(READ_RECEIVED && st_reg == CXP_HOLD && READ_DATA_VALID)
		|=> LINK_RDONE && LINK_RDATA == $past(READ_DATA) && !READ_RECEIVED;
	endproperty
	a_capture: assert property (p_capture) else $error("capture wrong");

	property p_ignore;
		@(posedge SYS_CLK) disable iff (RST)
		(st_reg != CXP_HOLD && READ_DATA_VALID && !(st_reg == CXP_PULSE
		&& rd_reg)) |=> !LINK_RDONE;
	endproperty
	a_ignore: assert property (p_ignore) else $error("stray valid taken");

	property p_leg_hold;
		@(posedge SYS_CLK) disable iff (RST)
		(st_reg == CXP_IDLE && LINK_RD && LEG_EN
		&& LINK_ADDR.reg_num >= `CXP_LEG_LO
		&& LINK_ADDR.reg_num <= `CXP_LEG_HI)
		|=> READ_RECEIVED ##1 (READ_RECEIVED || $past(READ_DATA_VALID));
	endproperty
	a_leg_hold: assert property (p_leg_hold)
		else $error("legacy read not held");

	property p_ext_hold;
		@(posedge SYS_CLK) disable iff (RST)
		(st_reg == CXP_IDLE && LINK_RD && EXT_EN
		&& LINK_ADDR.reg_num >= `CXP_EXT_LO
		&& LINK_ADDR.reg_num <= `CXP_EXT_HI)
		|=> READ_RECEIVED ##1 (READ_RECEIVED || $past(READ_DATA_VALID));
	endproperty
	a_ext_hold: assert property (p_ext_hold)
		else $error("extended read not held");

	property p_wr_be;
		@(posedge SYS_CLK) disable iff (RST)
		(st_reg == CXP_IDLE && !LINK_RD && LINK_WR)
		|=> REQ_WDATA.be == $past(LINK_WDATA.be);
	endproperty
	a_wr_be: assert property (p_wr_be)
		else $error("byte enables wrong");

	property p_ignore_pulse;
		@(posedge SYS_CLK) disable iff (RST)
		(st_reg == CXP_PULSE && rd_reg && READ_DATA_VALID)
		|=> LINK_RDONE && LINK_RDATA == 32'h0;
	endproperty
	a_ignore_pulse: assert property (p_ignore_pulse)
		else $error("pulse read took data");

	property p_plain_done;
		@(posedge SYS_CLK) disable iff (RST)
		(st_reg == CXP_IDLE && LINK_RD && !LEG_EN && !EXT_EN)
		|=> ##1 LINK_RDONE && LINK_RDATA == 32'h0;
	endproperty
	a_plain_done: assert property (p_plain_done)
		else $error("plain read not finished");
endmodule : cxp_top

//--- testbench/cxp_user_model.sv
// user-side register model answering extension reads
module cxp_user_model
	import cxp_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic READ_RECEIVED,
	input wire cxp_addr_t REQ_ADDR,
	input wire logic [3:0] DLY,
	output logic [31:0] READ_DATA,
	output logic READ_DATA_VALID
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_reg;
	logic done_reg;
	always_ff @(posedge SYS_CLK) begin
		cnt_reg <= (RST || !READ_RECEIVED) ? 4'h0 : cnt_reg + 4'h1;
		done_reg <= !RST && READ_RECEIVED && (done_reg || READ_DATA_VALID);
	end
	// one valid per pending request, after DLY cycles
	assign READ_DATA_VALID = READ_RECEIVED && !done_reg
		&& cnt_reg == DLY;
	assign READ_DATA = READ_DATA_VALID ? {REQ_ADDR, 14'h1ab5}
		: {~REQ_ADDR, 14'h2e4a};
endmodule : cxp_user_model

//--- testbench/cxp_top_test.sv
// self-checking bench of the configuration extension port
module cxp_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, leg = 0, ext = 0, lrd = 0, lwr = 0;
	logic busy, rdone, rr, wr, uv;
	logic [17:0] la = 0, ra, cap;
	logic [35:0] lw = 0, rw;
	logic [31:0] rd32, ud, seed = 32'h60;
	logic [3:0] dly = 0, len = 0;
	logic [53:0] rq[$], wq[$];
	logic [9:0] regs[7] = '{10'h00f, 10'h010, 10'h01f, 10'h020, 10'h0ff,
		10'h100, 10'h3ff};
	int fails = 0, num_checks = 0;
	cxp_top cxp_top_i(.SYS_CLK(clk), .RST(rst), .LEG_EN(leg), .EXT_EN(ext),
		.LINK_RD(lrd), .LINK_WR(lwr), .LINK_ADDR(la), .LINK_WDATA(lw),
		.LINK_BUSY(busy), .LINK_RDONE(rdone), .LINK_RDATA(rd32),
		.READ_RECEIVED(rr), .WRITE_RECEIVED(wr), .REQ_ADDR(ra), .REQ_WDATA(rw),
		.READ_DATA(ud), .READ_DATA_VALID(uv));
	cxp_user_model cxp_user_model_i(.SYS_CLK(clk), .RST(rst),
		.READ_RECEIVED(rr), .REQ_ADDR(ra), .DLY(dly), .READ_DATA(ud),
		.READ_DATA_VALID(uv));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(string n, logic [53:0] e, logic [53:0] s);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic req(logic r, logic [17:0] a, logic [35:0] w, logic l,
		logic x, logic [3:0] d);
		logic usr;
		usr = r && ((l && a[17:8] >= 10'h010 && a[17:8] <= 10'h01f)
			|| (x && a[17:8] >= 10'h100));
		if (r) rq.push_back({usr ? d + 4'h1 : 4'h1, a,
			usr ? {a, 14'h1ab5} : 32'h0});
		else wq.push_back({a, w});
		leg = l;
		ext = x;
		dly = d;
		lrd = r;
		lwr = !r;
		la = a;
		lw = w;
		@(negedge clk);
		chk("busy", 54'h1, 54'(busy));
		lrd = 0;
		lwr = 0;
		for (int i = 0; i < 40 && (busy || i < 2); i++) @(negedge clk);
		chk("idle", 54'h0, 54'(busy));
	endtask : req
	task automatic complete_run();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////
	initial forever #5 clk = ~clk;
	always @(negedge clk) begin
		if (rr) begin
			if (len == 0) cap = ra;
			len++;
		end
		if (wr) chk("write", wq.pop_front(), {ra, rw});
		if (rdone) begin
			chk("read", rq.pop_front(),
				{len, cap, rd32});
			len = 0;
		end
	end
	initial begin
		#100000;
		fails++;
		complete_run();
	end
	initial begin
		repeat (12) @(negedge clk);
		rst = 0;
		foreach (regs[i]) for (int m = 0; m < 4; m++) begin
			req(1, {regs[i], 8'h05}, 36'h0, m[0], m[1], 4'(m));
			req(0, {regs[i], 8'ha3}, {xs(), 4'(m)}, m[0], m[1], 4'h0);
		end
		$display("test directed done");
		repeat (40) req(1'(xs()), 18'(xs()), {xs(), 4'(xs())}, 1'(xs()),
			1'(xs()), 4'(xs() % 4));
		repeat (4) @(negedge clk);
		chk("left", 54'h0, 54'(rq.size() + wq.size()));
		$display("test random done");
		complete_run();
	end
endmodule : cxp_top_test
